/* inc/rsch_pkg.sv */
// constants and encodings of the remote system command handler
//
// How it works
// RULE1: prompt on: send '>' after each command
// RULE2: prompt query reads 1 on, 0 off
// RULE3: errors queue first-in first-out, reads remove
// RULE4: empty queue reads code 0, no error
// RULE5: over 15 errors: keep oldest, last -350
// RULE6: full error read gives code and text
// RULE7: code read gives numeric code only
// RULE8: list read gives up to 15 codes, else 0
// RULE9: unlocked: any host command enters remote
// RULE10: remote unlocked: only local key works
// RULE11: lockout on: all keys ignored, lockout state
// RULE12: bus lockout message 0x11 also locks out
// RULE13: only lockout off command releases lockout
// RULE14: lockout query: 0 unlocked, 1 locked
// RULE15: unlock on password match; gates protected commands
// RULE16: relock only on password match
// RULE17: password change only on old password match
// RULE18: password query: 1 enabled, 0 clear
// RULE19: factory wipe restores defaults and password
// RULE20: version query returns year dot revision
// RULE21: external source: grounded input applies setpoints
// RULE22: external source cancels continuous, waits initiate
// RULE23: protected command while locked queues -203
// RULE24: wrong unlock password queues -221
// RULE25: host should read errors out regularly
package rsch_pkg;

  // apb register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_ARG0 = 8'h04;
  localparam logic [7:0] ADDR_ARG1 = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_ERR_FULL = 8'h10;
  localparam logic [7:0] ADDR_ERR_CODE = 8'h14;
  localparam logic [7:0] ADDR_VERSION = 8'h1C;
  localparam logic [7:0] ADDR_TRIG_VOLT = 8'h20;
  localparam logic [7:0] ADDR_TRIG_CURR = 8'h24;
  localparam logic [7:0] ADDR_ERR_LIST = 8'h40;

  // status register bit positions
  localparam int ST_PROMPT = 0;
  localparam int ST_KLOC = 1;
  localparam int ST_REMOTE = 2;
  localparam int ST_PASS = 3;
  localparam int ST_TRIG_EXT = 4;
  localparam int ST_CONT = 5;
  localparam int ST_WAIT_INIT = 6;
  localparam int ST_ERR_CNT_LSB = 8;

  // command opcodes written to the command register
  typedef enum logic [7:0] {
    OP_NONE = 8'h00,
    OP_PROMPT = 8'h01,
    OP_KLOC = 8'h02,
    OP_LLO = 8'h03,
    OP_PASS_CEN = 8'h04,
    OP_PASS_CDIS = 8'h05,
    OP_PASS_NEW = 8'h06,
    OP_SEC_IMM = 8'h07,
    OP_TRIG_SOUR = 8'h08,
    OP_INIT_CONT = 8'h09,
    OP_INIT_IMM = 8'h0A,
    OP_BUS_TRIG = 8'h0B,
    OP_PROT = 8'h0C,
    OP_ERR_PUSH = 8'h0D
  } rsch_op_t;

  // error queue
  localparam int ERR_DEPTH = 15;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_PROTECTED = 16'hFF35;
  localparam logic [15:0] ERR_BAD_PASS = 16'hFF23;
  localparam logic [15:0] ERR_OVERFLOW = 16'hFEA2;

  // message text indices handed to the text formatter
  localparam logic [7:0] MSG_NONE = 8'h00;
  localparam logic [7:0] MSG_PROTECTED = 8'h01;
  localparam logic [7:0] MSG_BAD_PASS = 8'h02;
  localparam logic [7:0] MSG_OVERFLOW = 8'h03;
  localparam logic [7:0] MSG_OTHER = 8'hFF;

  // misc values
  localparam logic [7:0] PROMPT_CHAR = 8'h3E;
  localparam logic [7:0] LLO_CODE = 8'h11;
  localparam logic [15:0] VERSION_YEAR = 16'h07D3;
  localparam logic [15:0] VERSION_REV = 16'h0000;
  localparam logic [31:0] PASS_DEFAULT = 32'h0000_0000;
  // factory default time value 0.01 s, in milliseconds
  localparam logic [15:0] DEF_TIME_MS = 16'h000A;
  // factory default protection margin over rated maximum, in percent
  localparam logic [7:0] DEF_PROT_MARGIN_PCT = 8'h0A;

endpackage : rsch_pkg

/* design/rsch_err_queue.sv */
// fifteen-entry error code queue with overflow marker
`timescale 1ns/1ps
module rsch_err_queue
(
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // push side
  input logic push,
  input logic [15:0] push_code,
  // pop side
  input logic pop,
  output logic [15:0] head_code,
  output logic [3:0] count,
  // random read for the list query
  input logic [3:0] peek_idx,
  output logic [15:0] peek_code
);

  logic [15:0] mem_reg [rsch_pkg::ERR_DEPTH];  // entries, flip-flops
  logic [3:0] rd_reg;  // index of oldest entry
  logic [3:0] cnt_reg;  // number of stored entries
  logic full;
  logic do_pop;
  logic do_store;

  // circular index add modulo the depth
  function automatic logic [3:0] wrap_add(input logic [3:0] a, input logic [3:0] b);
    logic [4:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= 5'(rsch_pkg::ERR_DEPTH))
      s = s - 5'(rsch_pkg::ERR_DEPTH);
    return s[3:0];
  endfunction : wrap_add

  assign full = (cnt_reg == 4'(rsch_pkg::ERR_DEPTH));
  assign do_pop = pop && (cnt_reg != 4'h0);
  assign do_store = push && (!full || do_pop);

  // empty queue answers code 0
  assign head_code = (cnt_reg == 4'h0) ? rsch_pkg::ERR_NONE : mem_reg[rd_reg];  // [RULE4]
  assign count = cnt_reg;
  assign peek_code = (peek_idx < cnt_reg) ? mem_reg[wrap_add(rd_reg, peek_idx)]
                                          : rsch_pkg::ERR_NONE;  // [RULE8]

  // entry storage: append, or mark overflow in the last slot
  always_ff @(posedge ref_clk)
  begin
    if (do_store)
    begin
      mem_reg[wrap_add(rd_reg, cnt_reg)] <= push_code;  // [RULE3]
    end
    else if (push && full)
    begin
      // oldest kept, newest dropped, last slot shows overflow
      mem_reg[wrap_add(rd_reg, 4'(rsch_pkg::ERR_DEPTH - 1))] <= rsch_pkg::ERR_OVERFLOW;  // [RULE5]
    end
  end

  // read pointer and fill count
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_reg <= 4'h0;
      cnt_reg <= 4'h0;
    end
    else
    begin
      if (do_pop)
        rd_reg <= wrap_add(rd_reg, 4'h1);  // [RULE3]
      cnt_reg <= cnt_reg + 4'(do_store) - 4'(do_pop);
    end
  end

endmodule : rsch_err_queue

/* design/rsch_top.sv */
// remote system command handler: apb registers, lockout, password, errors, trigger
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module rsch_top
(
  // clock and reset
  input logic ref_clk,
  input logic rst_n,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // front panel keys and external trigger pins, asynchronous
  input logic key_local_pin,
  input logic key_other_pin,
  input logic ext_trig_n_pin,
  // prompt character stream toward the serial sender
  output logic prompt_valid,
  output logic [7:0] prompt_data,
  // panel state
  output logic key_accept,
  output logic remote_mode,
  output logic lockout,
  // protected command hand-off
  output logic prot_go,
  output logic [31:0] prot_arg,
  // factory wipe toward the settings store
  output logic nv_wipe,
  output logic [15:0] nv_def_time_ms,
  output logic [7:0] nv_def_margin_pct,
  // trigger and initiation
  output logic trig_apply,
  output logic [31:0] out_volt,
  output logic [31:0] out_curr,
  output logic cont_init,
  output logic wait_init
);

  // pin synchronisers
  logic [2:0] pin_in;  // raw pins
  logic [2:0] s1_reg;  // first stage
  logic [2:0] s2_reg;  // second stage
  logic [2:0] s3_reg;  // third stage
  logic [2:0] pin_stable_reg;  // accepted level
  logic [2:0] pin_rise;  // accepted rising change, one cycle

  assign pin_in = {ext_trig_n_pin, key_other_pin, key_local_pin};

  // three flops per pin; a change counts when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          // trigger idles high, keys idle low
          s1_reg[gi] <= (gi == 2) ? 1'b1 : 1'b0;
          s2_reg[gi] <= (gi == 2) ? 1'b1 : 1'b0;
          s3_reg[gi] <= (gi == 2) ? 1'b1 : 1'b0;
          pin_stable_reg[gi] <= (gi == 2) ? 1'b1 : 1'b0;
        end
        else
        begin
          s1_reg[gi] <= pin_in[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
            pin_stable_reg[gi] <= s3_reg[gi];
        end
      end
      assign pin_rise[gi] = (s2_reg[gi] == s3_reg[gi]) && s3_reg[gi] && !pin_stable_reg[gi];
    end
  endgenerate

  logic key_local_ev;  // local key pressed
  logic key_other_ev;  // any other key pressed
  logic trig_fall_ev;  // trigger input grounded
  assign key_local_ev = pin_rise[0];
  assign key_other_ev = pin_rise[1];
  assign trig_fall_ev = (s2_reg[2] == s3_reg[2]) && !s3_reg[2] && pin_stable_reg[2];

  // apb decode
  logic setup_ph;  // setup cycle
  logic wr_acc;  // write taken at this edge
  logic rd_acc;  // read completes at this edge
  logic [31:0] rd_mux;  // read data for the addressed register
  logic addr_ok;  // address is mapped
  logic [31:0] prdata_reg;
  logic pslverr_reg;

  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite && !pslverr_reg;
  assign rd_acc = psel && penable && !pwrite && !pslverr_reg;
  assign pready = psel && penable;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  // state registers
  logic [31:0] arg0_reg;  // first command argument
  logic [31:0] arg1_reg;  // second command argument
  logic [31:0] tvolt_reg;  // stored trigger voltage setpoint
  logic [31:0] tcurr_reg;  // stored trigger current setpoint
  logic prompt_on_reg;  // serial prompt switch
  logic kloc_reg;  // local lockout
  logic remote_reg;  // remote operation
  logic pass_en_reg;  // password-enabled state
  logic [31:0] pass_reg;  // stored password
  logic trig_ext_reg;  // external trigger source selected
  logic cont_reg;  // continuous initiation
  logic wait_reg;  // waiting for immediate initiate
  logic cmd_go;  // command register written
  rsch_pkg::rsch_op_t op;  // decoded opcode

  assign cmd_go = wr_acc && (paddr == rsch_pkg::ADDR_CMD);
  assign op = rsch_pkg::rsch_op_t'(pwdata[7:0]);

  // error queue
  logic eq_push;
  logic [15:0] eq_code;
  logic eq_pop;
  logic [15:0] eq_head;
  logic [3:0] eq_count;
  logic [3:0] eq_peek_idx;
  logic [15:0] eq_peek;

  // a read of either error register takes the oldest entry away
  assign eq_pop = rd_acc && ((paddr == rsch_pkg::ADDR_ERR_FULL) ||
                             (paddr == rsch_pkg::ADDR_ERR_CODE));  // [RULE3]
  assign eq_peek_idx = paddr[5:2];

  // error sources: bad password, refused protected command, host push
  always_comb
  begin
    eq_push = 1'b0;
    eq_code = rsch_pkg::ERR_NONE;
    if (cmd_go)
    begin
      case (op)
        rsch_pkg::OP_PASS_CEN:
        begin
          if (arg0_reg != pass_reg)
          begin
            eq_push = 1'b1;
            eq_code = rsch_pkg::ERR_BAD_PASS;  // [RULE24]
          end
        end
        rsch_pkg::OP_PROT:
        begin
          if (!pass_en_reg)
          begin
            eq_push = 1'b1;
            eq_code = rsch_pkg::ERR_PROTECTED;  // [RULE23]
          end
        end
        rsch_pkg::OP_ERR_PUSH:
        begin
          eq_push = 1'b1;
          eq_code = arg0_reg[15:0];
        end
        default: eq_push = 1'b0;
      endcase
    end
  end

  rsch_err_queue u_err_queue
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .push(eq_push),
    .push_code(eq_code),
    .pop(eq_pop),
    .head_code(eq_head),
    .count(eq_count),
    .peek_idx(eq_peek_idx),
    .peek_code(eq_peek)
  );

  // maps an error code to the index of its message text
  function automatic logic [7:0] msg_index(input logic [15:0] code);
    case (code)
      rsch_pkg::ERR_NONE: return rsch_pkg::MSG_NONE;
      rsch_pkg::ERR_PROTECTED: return rsch_pkg::MSG_PROTECTED;
      rsch_pkg::ERR_BAD_PASS: return rsch_pkg::MSG_BAD_PASS;
      rsch_pkg::ERR_OVERFLOW: return rsch_pkg::MSG_OVERFLOW;
      default: return rsch_pkg::MSG_OTHER;
    endcase
  endfunction : msg_index

  // read mux
  always_comb
  begin
    addr_ok = 1'b1;
    rd_mux = 32'h0000_0000;
    if (paddr >= rsch_pkg::ADDR_ERR_LIST)
    begin
      // list window: one code per word, zero past the fill
      if (paddr[5:2] < 4'(rsch_pkg::ERR_DEPTH) && paddr[1:0] == 2'b00 && paddr[7:6] == 2'b01)
        rd_mux = {{16{eq_peek[15]}}, eq_peek};  // [RULE8]
      else
        addr_ok = 1'b0;
    end
    else
    begin
      case (paddr)
        rsch_pkg::ADDR_CMD: rd_mux = 32'h0000_0000;
        rsch_pkg::ADDR_ARG0: rd_mux = arg0_reg;
        rsch_pkg::ADDR_ARG1: rd_mux = arg1_reg;
        rsch_pkg::ADDR_STATUS:
        begin
          rd_mux[rsch_pkg::ST_PROMPT] = prompt_on_reg;  // [RULE2]
          rd_mux[rsch_pkg::ST_KLOC] = kloc_reg;  // [RULE14]
          rd_mux[rsch_pkg::ST_REMOTE] = remote_reg;
          rd_mux[rsch_pkg::ST_PASS] = pass_en_reg;  // [RULE18]
          rd_mux[rsch_pkg::ST_TRIG_EXT] = trig_ext_reg;
          rd_mux[rsch_pkg::ST_CONT] = cont_reg;
          rd_mux[rsch_pkg::ST_WAIT_INIT] = wait_reg;
          rd_mux[rsch_pkg::ST_ERR_CNT_LSB +: 4] = eq_count;
        end
        // code with its message index for the text formatter
        rsch_pkg::ADDR_ERR_FULL: rd_mux = {8'h00, msg_index(eq_head), eq_head};  // [RULE6]
        // code alone, sign extended
        rsch_pkg::ADDR_ERR_CODE: rd_mux = {{16{eq_head[15]}}, eq_head};  // [RULE7]
        rsch_pkg::ADDR_VERSION:
          rd_mux = {rsch_pkg::VERSION_YEAR, rsch_pkg::VERSION_REV};  // [RULE20]
        rsch_pkg::ADDR_TRIG_VOLT: rd_mux = tvolt_reg;
        rsch_pkg::ADDR_TRIG_CURR: rd_mux = tcurr_reg;
        default: addr_ok = 1'b0;
      endcase
    end
  end

  // read data and error are captured in the setup cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= !addr_ok;
    end
  end

  // argument and setpoint registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      arg0_reg <= 32'h0000_0000;
      arg1_reg <= 32'h0000_0000;
      tvolt_reg <= 32'h0000_0000;
      tcurr_reg <= 32'h0000_0000;
    end
    else if (wr_acc)
    begin
      case (paddr)
        rsch_pkg::ADDR_ARG0: arg0_reg <= pwdata;
        rsch_pkg::ADDR_ARG1: arg1_reg <= pwdata;
        rsch_pkg::ADDR_TRIG_VOLT: tvolt_reg <= pwdata;
        rsch_pkg::ADDR_TRIG_CURR: tcurr_reg <= pwdata;
        default: arg0_reg <= arg0_reg;
      endcase
    end
  end

  // prompt
  // after each parsed command, emit one '>' while the switch is on
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prompt_on_reg <= 1'b0;
      prompt_valid <= 1'b0;
      prompt_data <= 8'h00;
    end
    else
    begin
      if (cmd_go && op == rsch_pkg::OP_PROMPT)
        prompt_on_reg <= arg0_reg[0];
      prompt_valid <= cmd_go && prompt_on_reg;  // [RULE1]
      prompt_data <= rsch_pkg::PROMPT_CHAR;
    end
  end

  // local, remote and lockout
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      kloc_reg <= 1'b0;
      remote_reg <= 1'b0;
      key_accept <= 1'b0;
    end
    else
    begin
      key_accept <= 1'b0;
      if (cmd_go && ((op == rsch_pkg::OP_KLOC && arg0_reg[0]) ||
                     (op == rsch_pkg::OP_LLO && arg0_reg[7:0] == rsch_pkg::LLO_CODE)))
      begin
        kloc_reg <= 1'b1;  // [RULE11] [RULE12]
        remote_reg <= 1'b1;
      end
      else if (cmd_go && op == rsch_pkg::OP_KLOC)
      begin
        // only the host releases lockout; the command itself still means remote
        kloc_reg <= 1'b0;  // [RULE13]
        remote_reg <= 1'b1;  // [RULE9]
      end
      else if (cmd_go && !kloc_reg)
        remote_reg <= 1'b1;  // [RULE9]
      else if (!kloc_reg && remote_reg && key_local_ev)
        remote_reg <= 1'b0;  // [RULE10]
      else if (!kloc_reg && !remote_reg && key_other_ev)
      begin
        // other keys work only in local operation; lockout blocks all keys
        key_accept <= 1'b1;  // [RULE10] [RULE11]
      end
    end
  end

  // password
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pass_en_reg <= 1'b0;
      pass_reg <= rsch_pkg::PASS_DEFAULT;
    end
    else if (cmd_go)
    begin
      case (op)
        rsch_pkg::OP_PASS_CEN:
        begin
          if (arg0_reg == pass_reg)
            pass_en_reg <= 1'b1;  // [RULE15] [RULE24]
        end
        rsch_pkg::OP_PASS_CDIS:
        begin
          if (arg0_reg == pass_reg)
            pass_en_reg <= 1'b0;  // [RULE16]
        end
        rsch_pkg::OP_PASS_NEW:
        begin
          if (arg0_reg == pass_reg)
            pass_reg <= arg1_reg;  // [RULE17]
        end
        rsch_pkg::OP_SEC_IMM: pass_reg <= rsch_pkg::PASS_DEFAULT;  // [RULE19]
        default: pass_en_reg <= pass_en_reg;
      endcase
    end
  end

  // protected hand-off and factory wipe
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      prot_go <= 1'b0;
      prot_arg <= 32'h0000_0000;
      nv_wipe <= 1'b0;
      nv_def_time_ms <= rsch_pkg::DEF_TIME_MS;
      nv_def_margin_pct <= rsch_pkg::DEF_PROT_MARGIN_PCT;
    end
    else
    begin
      // protected command passes only while enabled
      prot_go <= cmd_go && op == rsch_pkg::OP_PROT && pass_en_reg;  // [RULE15]
      if (cmd_go && op == rsch_pkg::OP_PROT && pass_en_reg)
        prot_arg <= arg0_reg;
      nv_wipe <= cmd_go && op == rsch_pkg::OP_SEC_IMM;  // [RULE19]
    end
  end

  // trigger source and initiation
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      trig_ext_reg <= 1'b0;
      cont_reg <= 1'b0;
      wait_reg <= 1'b0;
    end
    else if (cmd_go)
    begin
      case (op)
        rsch_pkg::OP_TRIG_SOUR:
        begin
          trig_ext_reg <= arg0_reg[0];
          if (arg0_reg[0] && cont_reg)
          begin
            cont_reg <= 1'b0;  // [RULE22]
            wait_reg <= 1'b1;
          end
        end
        rsch_pkg::OP_INIT_CONT: cont_reg <= arg0_reg[0];
        rsch_pkg::OP_INIT_IMM: wait_reg <= 1'b0;
        default: wait_reg <= wait_reg;
      endcase
    end
  end

  // setpoints applied on grounded input (external) or bus trigger (internal)
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      trig_apply <= 1'b0;
      out_volt <= 32'h0000_0000;
      out_curr <= 32'h0000_0000;
    end
    else
    begin
      trig_apply <= 1'b0;
      if ((trig_ext_reg && trig_fall_ev) ||
          (!trig_ext_reg && cmd_go && op == rsch_pkg::OP_BUS_TRIG))
      begin
        trig_apply <= 1'b1;  // [RULE21]
        out_volt <= tvolt_reg;
        out_curr <= tcurr_reg;
      end
    end
  end

  assign remote_mode = remote_reg;
  assign lockout = kloc_reg;
  assign cont_init = cont_reg;
  assign wait_init = wait_reg;

endmodule : rsch_top

/* bench/rsch_top_asserts.sv */
// port checks of the command handler
`timescale 1ns/1ps
module rsch_top_asserts
(
  // clock, reset and apb request
  input logic ref_clk,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  // panel and command outputs
  input logic prompt_valid,
  input logic [7:0] prompt_data,
  input logic key_accept,
  input logic remote_mode,
  input logic lockout,
  input logic prot_go,
  input logic nv_wipe,
  input logic [15:0] nv_def_time_ms,
  input logic [7:0] nv_def_margin_pct,
  input logic cont_init,
  input logic wait_init
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // command register write in its access phase
  logic cmd_wr;
  assign cmd_wr = psel && penable && pwrite && (paddr == 8'h00);
  a_prompt_char: assert property (prompt_valid |-> prompt_data == 8'h3E ##1 !prompt_valid)
    else $error("prompt pulse malformed");
  a_prompt_cause: assert property (prompt_valid |-> $past(cmd_wr))
    else $error("prompt without command");
  a_remote_entry: assert property (cmd_wr && !lockout |=> remote_mode)
    else $error("command left device local");
  a_remote_keys: assert property (remote_mode && $past(remote_mode) |-> !key_accept)
    else $error("key taken in remote");
  a_lock_remote: assert property (lockout |-> remote_mode)
    else $error("lockout without remote");
  a_lock_keys: assert property (lockout && $past(lockout) |-> !key_accept)
    else $error("key taken in lockout");
  a_lock_sticky: assert property ($fell(lockout) |-> $past(cmd_wr))
    else $error("lockout left without command");
  a_prot_cause: assert property (prot_go |-> $past(cmd_wr && pwdata[7:0] == 8'h0C))
    else $error("protected go without command");
  a_wipe_dflt: assert property (nv_wipe |-> nv_def_time_ms == 16'h000A && nv_def_margin_pct == 8'h0A)
    else $error("wipe defaults wrong");
  a_cont_cancel: assert property ($rose(wait_init) |-> !cont_init && $past(cmd_wr))
    else $error("continuous not cancelled");
endmodule : rsch_top_asserts
bind rsch_top rsch_top_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prompt_valid(prompt_valid), .prompt_data(prompt_data), .key_accept(key_accept),
  .remote_mode(remote_mode), .lockout(lockout), .prot_go(prot_go), .nv_wipe(nv_wipe),
  .nv_def_time_ms(nv_def_time_ms), .nv_def_margin_pct(nv_def_margin_pct),
  .cont_init(cont_init), .wait_init(wait_init));

/* bench/rsch_host_model.sv */
// apb host model issuing register transfers
`timescale 1ns/1ps
module rsch_host_model
(
  // clock
  input logic ref_clk,
  // apb request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // a transfer never saw pready
  output logic timed_out
);
  // idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    timed_out = 1'b0;
  end
  // setup cycle, then access held until pready
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      timed_out <= 1'b1;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer
endmodule : rsch_host_model

/* bench/rsch_tb_top.sv */
// self-checking bench of the command handler
`timescale 1ns/1ps
module rsch_tb_top;
  localparam logic [31:0] ONE = 32'h0000_0001;
  localparam logic [31:0] NIL = 32'h0000_0000;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, tmo, e;
  logic key_l, key_o, trg_n, pv, ka, rem, lck, pg, nw, ta, ci, wi;
  logic [7:0] paddr, pd, nm;
  logic [15:0] nt;
  logic [31:0] pwdata, prdata, pa, ov, oc, seed, q, k, v, c;
  logic [15:0] codes [17];
  int fail_count, checks, n_pr, n_ka, n_pg, n_nw, n_ta;
  rsch_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_local_pin(key_l), .key_other_pin(key_o), .ext_trig_n_pin(trg_n),
    .prompt_valid(pv), .prompt_data(pd), .key_accept(ka), .remote_mode(rem), .lockout(lck),
    .prot_go(pg), .prot_arg(pa), .nv_wipe(nw), .nv_def_time_ms(nt), .nv_def_margin_pct(nm),
    .trig_apply(ta), .out_volt(ov), .out_curr(oc), .cont_init(ci), .wait_init(wi));
  rsch_host_model hst (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timed_out(tmo));
  // xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // sign extension of a queued code
  function automatic logic [31:0] sx(input logic [15:0] x);
    return {{16{x[15]}}, x};
  endfunction : sx
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, x);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    hst.xfer(1'b1, a, d, q, e);
  endtask : wr
  task rd(input logic [7:0] a);
    hst.xfer(1'b0, a, NIL, q, e);
  endtask : rd
  // arguments first, then the opcode
  task cmd(input logic [7:0] op, input logic [31:0] a0, input logic [31:0] a1);
    wr(8'h04, a0);
    wr(8'h08, a1);
    wr(8'h00, {24'h00_0000, op});
    repeat (2) @(posedge ref_clk);
  endtask : cmd
  // one status bit
  task st(input int b, input logic x);
    rd(8'h0C);
    chk(32'(q[b]), 32'(x));
  endtask : st
  // press and release a key
  task key(input logic l);
    key_l <= l;
    key_o <= !l;
    repeat (8) @(posedge ref_clk);
    key_l <= 1'b0;
    key_o <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : key
  task wrap_up();
    if (tmo !== 1'b0)
      fail_count++;
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // pulse counters
  always @(posedge ref_clk)
  begin
    if (pv === 1'b1) n_pr++;
    if (ka === 1'b1) n_ka++;
    if (pg === 1'b1) n_pg++;
    if (nw === 1'b1) n_nw++;
    if (ta === 1'b1) n_ta++;
  end
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end
  initial
  begin
    seed = 32'h0000_bbaa;
    rst_n = 1'b0;
    key_l = 1'b0;
    key_o = 1'b0;
    trg_n = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(32'(rem), NIL);
    cmd(8'h01, ONE, NIL);
    chk(32'(rem), ONE);
    st(0, 1'b1);
    cmd(8'h3F, NIL, NIL);
    cmd(8'h01, NIL, NIL);
    st(0, 1'b0);
    cmd(8'h3F, NIL, NIL);
    chk(n_pr, 2);
    $display("prompt test done");
    key(1'b0);
    chk(n_ka, 0);
    key(1'b1);
    chk(32'(rem), NIL);
    key(1'b0);
    chk(n_ka, 1);
    cmd(8'h02, ONE, NIL);
    st(1, 1'b1);
    key(1'b1);
    key(1'b0);
    chk(n_ka, 1);
    chk({30'(0), lck, rem}, 3);
    cmd(8'h02, NIL, NIL);
    st(1, 1'b0);
    cmd(8'h03, 32'h0000_0011, NIL);
    chk(32'(lck), ONE);
    cmd(8'h02, NIL, NIL);
    $display("lockout test done");
    k = rnd() | ONE;
    cmd(8'h0C, k, NIL);
    cmd(8'h04, k, NIL);
    st(3, 1'b0);
    rd(8'h10);
    chk(q, 32'h0001_FF35);
    rd(8'h14);
    chk(q, sx(16'hFF23));
    rd(8'h14);
    chk(q, NIL);
    cmd(8'h04, NIL, NIL);
    st(3, 1'b1);
    cmd(8'h0C, k, NIL);
    chk(n_pg, 1);
    chk(pa, k);
    cmd(8'h06, NIL, k);
    cmd(8'h05, NIL, NIL);
    st(3, 1'b1);
    cmd(8'h05, k, NIL);
    st(3, 1'b0);
    cmd(8'h06, ~k, NIL);
    cmd(8'h04, k, NIL);
    st(3, 1'b1);
    cmd(8'h07, NIL, NIL);
    cmd(8'h05, NIL, NIL);
    st(3, 1'b0);
    chk(n_nw, 1);
    chk({nt, nm, pd}, 32'h000A_0A3E);
    repeat (16) rd(8'h14);
    $display("password test done");
    for (int i = 0; i < 17; i++)
    begin
      codes[i] = {4'h1, 12'(rnd())};
      cmd(8'h0D, {16'h0000, codes[i]}, NIL);
    end
    rd(8'h0C);
    chk(32'(q[11:8]), 32'h0000_000F);
    for (int i = 0; i < 15; i++)
    begin
      rd(8'(8'h40 + 4 * i));
      chk(q, (i < 14) ? sx(codes[i]) : sx(16'hFEA2));
    end
    rd(8'h10);
    chk(q, {16'h00FF, codes[0]});
    for (int i = 1; i < 14; i++)
    begin
      rd(8'h14);
      chk(q, sx(codes[i]));
    end
    rd(8'h14);
    chk(q, sx(16'hFEA2));
    rd(8'h40);
    chk(q, NIL);
    rd(8'h14);
    chk(q, NIL);
    rd(8'h1C);
    chk(q, 32'h07D3_0000);
    rd(8'h30);
    chk({q[31:1], e}, {31'h0000_0000, 1'b1});
    $display("error queue test done");
    v = rnd();
    c = rnd();
    wr(8'h20, v);
    wr(8'h24, c);
    cmd(8'h09, ONE, NIL);
    cmd(8'h08, ONE, NIL);
    chk({30'(0), ci, wi}, ONE);
    cmd(8'h0A, NIL, NIL);
    chk(32'(wi), NIL);
    trg_n <= 1'b0;
    for (int i = 0; i < 20 && n_ta == 0; i++) @(posedge ref_clk);
    chk(ov, v);
    chk(oc, c);
    chk(n_ta, 1);
    trg_n <= 1'b1;
    cmd(8'h08, NIL, NIL);
    wr(8'h20, c);
    cmd(8'h0B, NIL, NIL);
    chk(ov, c);
    chk(n_ta, 2);
    $display("trigger test done");
    wrap_up();
  end
endmodule : rsch_tb_top
